// >>> hw/iseb_pkg.sv
package iseb_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ISEB_DATA_W = 32;
   localparam int ISEB_ADDR_W = 12;
   localparam logic [ISEB_ADDR_W-1:0] ISEB_OFS_SET_LOW = 12'h000;
   localparam logic [ISEB_ADDR_W-1:0] ISEB_OFS_SET_HIGH = 12'h004;
   localparam logic [ISEB_ADDR_W-1:0] ISEB_OFS_STATUS = 12'h008;
   localparam logic [ISEB_DATA_W-1:0] ISEB_ENABLE_RESET = 32'h0000_0000;
   localparam logic [ISEB_DATA_W-1:0] ISEB_READ_ZERO = 32'h0000_0000;
   localparam int ISEB_NUM_BANKS = 2;
   localparam int ISEB_SRC_W = ISEB_DATA_W * ISEB_NUM_BANKS;
   localparam int ISEB_LANE_W = 8;

   // ----------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ISEB_ADDR_W-1:0] paddr;
      logic [ISEB_DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } iseb_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [ISEB_DATA_W-1:0] prdata;
   } iseb_apb_rsp_t;

   typedef enum logic [1:0] {
      ISEB_SEL_NONE,
      ISEB_SEL_LOW,
      ISEB_SEL_HIGH,
      ISEB_SEL_STATUS
   } iseb_sel_t;
endpackage

// >>> hw/iseb_set_bank.sv
`timescale 1ns/1ns
module iseb_set_bank
   import iseb_pkg::*;
#(
   parameter int WIDTH = ISEB_DATA_W
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_wr_en,
   input wire logic [WIDTH-1:0] i_wr_bits,
   output logic [WIDTH-1:0] o_enable
);
   logic [WIDTH-1:0] enable_q;
   logic [WIDTH-1:0] enable_d;

   // ----------------------------------------------------------------
   // Set-only storage
   // ----------------------------------------------------------------
   // OR in ones only.
   always_comb begin
      enable_d = enable_q;
      if (i_wr_en) begin
         enable_d = enable_q | i_wr_bits;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         enable_q <= WIDTH'(ISEB_ENABLE_RESET);
      end else begin
         enable_q <= enable_d;
      end
   end

   assign o_enable = enable_q;
endmodule

// >>> hw/iseb_top.sv
`timescale 1ns/1ns
module iseb_top
   import iseb_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ISEB_ADDR_W-1:0] i_paddr,
   input wire logic [ISEB_DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic o_pready,
   output logic o_pslverr,
   output logic [ISEB_DATA_W-1:0] o_prdata,
   input wire logic [ISEB_SRC_W-1:0] i_irq_req,
   output logic [ISEB_SRC_W-1:0] o_irq_fwd,
   output logic [ISEB_SRC_W-1:0] o_irq_enable
);
   iseb_apb_req_t req;
   iseb_apb_rsp_t rsp;
   iseb_sel_t sel;
   logic access;
   logic [ISEB_DATA_W-1:0] strb_mask;
   logic [ISEB_NUM_BANKS-1:0] bank_wr;
   logic [ISEB_SRC_W-1:0] enable_all;
   logic [ISEB_DATA_W-1:0] prdata_q;
   logic [ISEB_DATA_W-1:0] prdata_d;
   logic [ISEB_SRC_W-1:0] fwd_q;
   logic [ISEB_SRC_W-1:0] fwd_d;
   logic setup_rd;
   logic access_wr;
   logic addr_bad;
   logic write_bad;
   logic [ISEB_DATA_W-1:0] wr_bits;
   logic [ISEB_DATA_W-1:0] bank_word [ISEB_NUM_BANKS];
   logic [ISEB_DATA_W-1:0] status_word;
   logic [ISEB_DATA_W-1:0] read_word;

   // ----------------------------------------------------------------
   // Local constants
   // ----------------------------------------------------------------
   // Strobe lanes follow from the data width, but pstrb stays 4 bits wide, so a wider bus also needs a wider strobe.
   localparam int LANES = ISEB_DATA_W / ISEB_LANE_W;
   localparam int BANK_LOW = 0;
   localparam int BANK_HIGH = 1;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic iseb_sel_t decode(input logic [ISEB_ADDR_W-1:0] addr);
      iseb_sel_t s;
      s = ISEB_SEL_NONE;
      if (addr == ISEB_OFS_SET_LOW) begin
         s = ISEB_SEL_LOW;
      end else if (addr == ISEB_OFS_SET_HIGH) begin
         s = ISEB_SEL_HIGH;
      end else if (addr == ISEB_OFS_STATUS) begin
         s = ISEB_SEL_STATUS;
      end
      return s;
   endfunction

   // Only the two set-enable offsets take a write; the status word is read only.
   function automatic logic writable(input iseb_sel_t s);
      logic ok;
      ok = 1'h0;
      if (s == ISEB_SEL_LOW) begin
         ok = 1'h1;
      end else if (s == ISEB_SEL_HIGH) begin
         ok = 1'h1;
      end
      return ok;
   endfunction

   function automatic logic mapped(input iseb_sel_t s);
      return s != ISEB_SEL_NONE;
   endfunction

   function automatic iseb_sel_t bank_sel(input int bank);
      iseb_sel_t s;
      s = ISEB_SEL_LOW;
      if (bank == BANK_HIGH) begin
         s = ISEB_SEL_HIGH;
      end
      return s;
   endfunction

   function automatic logic [ISEB_DATA_W-1:0] pick_word(
      input iseb_sel_t s,
      input logic [ISEB_DATA_W-1:0] low,
      input logic [ISEB_DATA_W-1:0] high,
      input logic [ISEB_DATA_W-1:0] status
   );
      logic [ISEB_DATA_W-1:0] w;
      w = ISEB_READ_ZERO;
      if (s == ISEB_SEL_LOW) begin
         w = low;
      end else if (s == ISEB_SEL_HIGH) begin
         w = high;
      end else if (s == ISEB_SEL_STATUS) begin
         w = status;
      end
      return w;
   endfunction

   // ----------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------
   always_comb begin
      req.psel = i_psel;
      req.penable = i_penable;
      req.pwrite = i_pwrite;
      req.paddr = i_paddr;
      req.pwdata = i_pwdata;
      req.pstrb = i_pstrb;
   end

   // ----------------------------------------------------------------
   // Phase qualifiers
   // ----------------------------------------------------------------
   assign sel = decode(req.paddr);
   assign access = req.psel & req.penable;
   assign setup_rd = req.psel & ~req.penable & ~req.pwrite;
   assign access_wr = access & req.pwrite;
   assign addr_bad = ~mapped(sel);
   assign write_bad = req.pwrite & ~writable(sel);

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   // Byte strobes widen to a bit mask so that a partial write sets nothing in the untouched lanes.
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         assign strb_mask[lane*ISEB_LANE_W +: ISEB_LANE_W] = {ISEB_LANE_W{req.pstrb[lane]}};
      end
   endgenerate

   assign wr_bits = req.pwdata & strb_mask;

   // ----------------------------------------------------------------
   // Enable banks
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ISEB_NUM_BANKS; g++) begin : g_bank
         // Bank g covers sources 32*g upward.
         assign bank_wr[g] = access_wr & (sel == bank_sel(g));
         assign bank_word[g] = enable_all[g*ISEB_DATA_W +: ISEB_DATA_W];
         iseb_set_bank #(
            .WIDTH(ISEB_DATA_W)
         ) u_bank (
            .i_core_clk(i_core_clk),
            .i_sys_rst(i_sys_rst),
            .i_wr_en(bank_wr[g]),
            .i_wr_bits(wr_bits),
            .o_enable(enable_all[g*ISEB_DATA_W +: ISEB_DATA_W])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status view
   // ----------------------------------------------------------------
   // Folding the banks lets software poll one offset for any enabled source, at the cost of not knowing which.
   always_comb begin
      status_word = ISEB_READ_ZERO;
      for (int k = 0; k < ISEB_NUM_BANKS; k++) begin
         status_word = status_word | bank_word[k];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Read data is registered in the setup cycle so the access phase answers at once with no wait state.
   assign read_word = pick_word(sel, bank_word[BANK_LOW], bank_word[BANK_HIGH], status_word);

   always_comb begin
      prdata_d = prdata_q;
      if (setup_rd) begin
         prdata_d = read_word;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prdata_q <= ISEB_READ_ZERO;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Response
   // ----------------------------------------------------------------
   // Every access completes in its first cycle, so this block never stalls the bus.
   always_comb begin
      rsp.pready = 1'h1;
      rsp.pslverr = access & (addr_bad | write_bad);
      rsp.prdata = prdata_q;
   end

   assign o_pready = rsp.pready;
   assign o_pslverr = rsp.pslverr;
   assign o_prdata = rsp.prdata;

   // ----------------------------------------------------------------
   // Request gating
   // ----------------------------------------------------------------
   // Forward enabled requests.
   always_comb begin
      fwd_d = i_irq_req & enable_all;
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fwd_q <= '0;
      end else begin
         fwd_q <= fwd_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_irq_fwd = fwd_q;
   assign o_irq_enable = enable_all;
endmodule

// >>> verif/iseb_assertions.sv
`timescale 1ns/1ns
module iseb_assertions
   import iseb_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ISEB_ADDR_W-1:0] i_paddr,
   input wire logic [ISEB_DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [ISEB_DATA_W-1:0] o_prdata,
   input wire logic [ISEB_SRC_W-1:0] i_irq_req,
   input wire logic [ISEB_SRC_W-1:0] o_irq_fwd,
   input wire logic [ISEB_SRC_W-1:0] o_irq_enable
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic w, rl, rh, wl, wh;
   logic [31:0] m;
   assign m = i_pwdata & {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
   assign w = i_psel & i_penable & i_pwrite;
   assign wl = w && i_paddr == ISEB_OFS_SET_LOW;
   assign wh = w && i_paddr == ISEB_OFS_SET_HIGH;
   assign rl = i_psel && i_penable && !i_pwrite && i_paddr == ISEB_OFS_SET_LOW;
   assign rh = i_psel && i_penable && !i_pwrite && i_paddr == ISEB_OFS_SET_HIGH;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   AST_LOW_SET: assert property (wl |=> o_irq_enable[31:0] == ($past(o_irq_enable[31:0]) | $past(m)))
      else $error("low bank set wrong");
   AST_HIGH_SET: assert property (wh |=> o_irq_enable[63:32] == ($past(o_irq_enable[63:32]) | $past(m)))
      else $error("high bank set wrong");
   AST_LOW_HOLD: assert property (!wl |=> $stable(o_irq_enable[31:0])) else $error("low bank moved");
   AST_HIGH_HOLD: assert property (!wh |=> $stable(o_irq_enable[63:32])) else $error("high bank moved");
   AST_NO_CLEAR: assert property (1'h1 |=> ($past(o_irq_enable) & ~o_irq_enable) == '0) else $error("enable cleared");
   AST_READ_LOW: assert property (rl |-> o_prdata == o_irq_enable[31:0]) else $error("low read wrong");
   AST_READ_HIGH: assert property (rh |-> o_prdata == o_irq_enable[63:32]) else $error("high read wrong");
   AST_FWD: assert property (1'h1 |=> o_irq_fwd == $past(i_irq_req & o_irq_enable)) else $error("forward wrong");
   AST_NO_WAIT: assert property (i_psel && i_penable |-> o_pready) else $error("access phase stalled");
   COV_WL: cover property (wl);
   COV_RH: cover property (rh);
   COV_ERR: cover property (o_pslverr && i_penable);
endmodule
bind iseb_top iseb_assertions u_chk (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .i_pstrb, .o_pready, .o_pslverr, .o_prdata, .i_irq_req, .o_irq_fwd, .o_irq_enable);

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import iseb_pkg::*;
   logic i_core_clk = 1'h0, i_sys_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, hi, se;
   logic [ISEB_ADDR_W-1:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, rd, d, r = 32'h81442c84;
   logic [3:0] i_pstrb = '0, s;
   logic [63:0] i_irq_req = '0, en = '0;
   logic o_pready, o_pslverr;
   logic [31:0] o_prdata;
   logic [63:0] o_irq_fwd, o_irq_enable;
   int miscompares = 0, tests_run = 0;
   iseb_top dut (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
      .o_pready, .o_pslverr, .o_prdata, .i_irq_req, .o_irq_fwd, .o_irq_enable);
   initial forever #2 i_core_clk = ~i_core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected enables after a set-only write: lanes with a low strobe set nothing.
   function automatic logic [31:0] set_word(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      return old | (wd & {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}});
   endfunction
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] v);
      tests_run++;
      if (v !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, v);
      end
   endtask
   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   // Always ends one edge after release, so the next request never lands in the same step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
      i_psel <= 1'h1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      i_pstrb <= st;
      @(posedge i_core_clk);
      i_penable <= 1'h1;
      do @(posedge i_core_clk); while (o_pready !== 1'h1);
      rd = o_prdata;
      se = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      @(posedge i_core_clk);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #40000;
      miscompares++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_sys_rst <= 1'h0;
      @(posedge i_core_clk);
      chk("reset", 64'h0, o_irq_enable);
      for (int i = 0; i < 200; i++) begin
         r = lfsr(r);
         s = (i < 4) ? 4'hf : r[3:0];
         hi = r[4];
         r = lfsr(r);
         d = (i < 4) ? 32'h8000_0001 & {32{i[0]}} : r & lfsr(r);
         i_irq_req <= {lfsr(r), r};
         apb(1'h1, hi ? ISEB_OFS_SET_HIGH : ISEB_OFS_SET_LOW, d, s);
         if (hi) en[63:32] = set_word(en[63:32], d, s);
         else en[31:0] = set_word(en[31:0], d, s);
         chk("enable_low", {32'h0, en[31:0]}, {32'h0, o_irq_enable[31:0]});
         chk("enable_high", {32'h0, en[63:32]}, {32'h0, o_irq_enable[63:32]});
         apb(1'h0, hi ? ISEB_OFS_SET_HIGH : ISEB_OFS_SET_LOW, 32'h0, 4'h0);
         chk("read", {32'h0, hi ? en[63:32] : en[31:0]}, {32'h0, rd});
         chk("forward", i_irq_req & en, o_irq_fwd);
         if (i == 100) begin
            i_sys_rst <= 1'h1;
            @(posedge i_core_clk);
            i_sys_rst <= 1'h0;
            en = '0;
            @(posedge i_core_clk);
            chk("mid_reset", 64'h0, o_irq_enable);
         end
      end
      apb(1'h1, ISEB_OFS_STATUS, 32'hffff_ffff, 4'hf);
      chk("status_write", en, o_irq_enable);
      chk("status_err", 64'h1, {63'h0, se});
      apb(1'h0, ISEB_OFS_STATUS, 32'h0, 4'h0);
      chk("status_read", {32'h0, en[63:32] | en[31:0]}, {32'h0, rd});
      apb(1'h0, 12'h00c, 32'h0, 4'h0);
      chk("unmapped", {31'h0, 1'h1, 32'h0}, {31'h0, se, rd});
      stop_test;
   end
endmodule
